// *** shared/dsc_pkg.sv ***
// package for the device security state controller: state codes, fuse codes,
// csr map and key constants.
// assumes a single ref_clk domain and a 256-bit chip key from key storage.
package dsc_pkg;

  // run-time state, re-evaluated after every reset
  typedef enum logic [1:0] {
    DSC_RTS_EVAL    = 2'b00,
    DSC_RTS_SECURE  = 2'b01,
    DSC_RTS_NONSEC  = 2'b10,
    DSC_RTS_VIOL    = 2'b11
  } dsc_rts_t;

  // life-cycle state as reported to the rest of the chip
  typedef enum logic [1:0] {
    DSC_LC_UNLK_FACT = 2'b00,
    DSC_LC_LOCK_FACT = 2'b01,
    DSC_LC_UNLOCKED  = 2'b10,
    DSC_LC_LOCKED    = 2'b11
  } dsc_lc_t;

  // thermometer fuse codes; fuses only ever blow from 0 to 1
  localparam int          LC_FUSE_W        = 3;
  localparam logic [2:0]  LC_FUSE_UNLK_FACT = 3'h0;
  localparam logic [2:0]  LC_FUSE_LOCK_FACT = 3'h1;
  localparam logic [2:0]  LC_FUSE_UNLOCKED  = 3'h3;
  localparam logic [2:0]  LC_FUSE_LOCKED    = 3'h7;

  // key register
  localparam int             KEY_W       = 256;
  localparam int             KEY_WORDS   = 8;
  localparam logic [255:0]   MKEY_RST    = 256'h0;

  // csr map (12-bit csr address space)
  localparam logic [11:0]  CSR_MKEY_BASE  = 12'h7c0;
  localparam logic [11:0]  CSR_DEV_STATE  = 12'h7d0;
  localparam logic [11:0]  CSR_SEC_STORE  = 12'h7d1;

  // fields of the device state csr
  localparam int  DEV_STATE_RTS_LSB = 0;
  localparam int  DEV_STATE_LC_LSB  = 2;

  localparam logic [31:0]  SEC_STORE_RST = 32'h0;

endpackage : dsc_pkg

// *** shared/dsc_lc_if.sv ***
// interface between the state controller and the life-cycle fuse store.
// assumes both ends share ref_clk.
`timescale 1ns/1ps
`default_nettype none
interface dsc_lc_if;
  logic [2:0] fuse_val;
  logic       burn_req;
  logic [2:0] burn_val;

  modport ctrl (input fuse_val, output burn_req, output burn_val);
  modport store (output fuse_val, input burn_req, input burn_val);
endinterface : dsc_lc_if
`default_nettype wire

// *** verilog/dsc_lc_fuse.sv ***
// life-cycle fuse store: models one-time programmable bits.
// assumes fuse_blank_b is asserted only for a brand-new, unprogrammed part.
`timescale 1ns/1ps
`default_nettype none
module dsc_lc_fuse
  import dsc_pkg::*;
(
  // clock and blank-part init
  input  wire logic ref_clk,
  input  wire logic fuse_blank_b,
  // controller side
  dsc_lc_if.store   lc
);

  logic [2:0] fuse_q;
  logic [2:0] fuse_d;

  // bits can only be set, so the state can never move backwards
  always_comb begin
    fuse_d = fuse_q;
    if (lc.burn_req) begin
      fuse_d = fuse_q | lc.burn_val;
    end
  end

  // not touched by rst_b: the value survives every system reset
  always_ff @(posedge ref_clk) begin
    if (!fuse_blank_b) begin
      fuse_q <= LC_FUSE_UNLK_FACT;
    end else begin
      fuse_q <= fuse_d;
    end
  end

  assign lc.fuse_val = fuse_q;

endmodule : dsc_lc_fuse
`default_nettype wire

// *** verilog/dsc_state_ctrl.sv ***
// device security state controller: life-cycle plus run-time state, mkey csr
// and access gating for protected csrs.
// assumes boot rom drives the boot status strobes and csr requests are single cycle.
`timescale 1ns/1ps
`default_nettype none
module dsc_state_ctrl
  import dsc_pkg::*;
(
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic         fuse_blank_b,
  // boot and software events
  input  wire logic         boot_done,
  input  wire logic         boot_ok,
  input  wire logic         boot_err,
  input  wire logic         unsigned_sw,
  input  wire logic         sw_nonsec_req,
  input  wire logic         sec_fault,
  input  wire logic         lc_adv_req,
  // key source
  input  wire logic [255:0] chip_key,
  // csr access port
  input  wire logic         csr_req,
  input  wire logic         csr_we,
  input  wire logic [11:0]  csr_addr,
  input  wire logic [31:0]  csr_wdata,
  output logic      [31:0]  csr_rdata_q,
  output logic              csr_ack_q,
  output logic              csr_deny_q,
  // state and crypto key
  output logic      [1:0]   rts_q,
  output logic      [1:0]   lc_state_q,
  output logic      [255:0] crypto_key_q,
  output logic              crypto_key_vld_q
);

  dsc_lc_if lc_bus ();

  dsc_lc_fuse u_lc_fuse (
    .ref_clk      (ref_clk),
    .fuse_blank_b (fuse_blank_b),
    .lc           (lc_bus.store)
  );

  // fuse code to life-cycle value
  function automatic dsc_lc_t lc_decode(input logic [2:0] f);
    dsc_lc_t r;
    r = DSC_LC_UNLK_FACT;
    case (f)
      LC_FUSE_UNLK_FACT: r = DSC_LC_UNLK_FACT;
      LC_FUSE_LOCK_FACT: r = DSC_LC_LOCK_FACT;
      LC_FUSE_UNLOCKED:  r = DSC_LC_UNLOCKED;
      // any other pattern is treated as fully locked, the safe side
      default:           r = DSC_LC_LOCKED;
    endcase
    return r;
  endfunction

  function automatic logic lc_is_locked(input dsc_lc_t l);
    return (l == DSC_LC_LOCK_FACT) || (l == DSC_LC_LOCKED);
  endfunction

  // access decision per csr
  function automatic logic access_ok(input logic [11:0] a, input logic we,
                                     input dsc_rts_t r, input dsc_lc_t l);
    logic ok;
    ok = 1'b0;
    if (a[11:3] == CSR_MKEY_BASE[11:3]) begin
      ok = (r == DSC_RTS_SECURE);
    end else if (a == CSR_DEV_STATE) begin
      ok = !we;
    end else if (a == CSR_SEC_STORE) begin
      // secure storage is open in secure, or anywhere but violation in unlocked factory
      ok = (r == DSC_RTS_SECURE) ||
           ((l == DSC_LC_UNLK_FACT) && (r != DSC_RTS_VIOL));
    end
    return ok;
  endfunction

  dsc_lc_t          lc_now;
  dsc_rts_t         rts_s_q;
  dsc_rts_t         rts_d;
  logic [255:0]     mkey_q;
  logic [255:0]     mkey_d;
  logic [31:0]      store_q;
  logic [31:0]      store_d;
  logic [31:0]      rdata_d;
  logic             ack_d;
  logic             deny_d;
  logic [1:0]       lc_d;
  logic             burn_req;
  logic [2:0]       burn_val;

  assign lc_now = lc_decode(lc_bus.fuse_val);

  // run-time state machine
  always_comb begin
    rts_d = rts_s_q;
    case (rts_s_q)
      DSC_RTS_EVAL: begin
        if (boot_err || sec_fault) begin
          rts_d = DSC_RTS_VIOL;
        end else if (unsigned_sw && lc_is_locked(lc_now)) begin
          rts_d = DSC_RTS_VIOL;
        end else if (unsigned_sw) begin
          rts_d = DSC_RTS_NONSEC;
        end else if (boot_done && boot_ok) begin
          rts_d = DSC_RTS_SECURE;
        end else if (boot_done) begin
          rts_d = DSC_RTS_VIOL;
        end
      end
      DSC_RTS_SECURE: begin
        if (sec_fault) begin
          rts_d = DSC_RTS_VIOL;
        end else if (unsigned_sw && lc_is_locked(lc_now)) begin
          rts_d = DSC_RTS_VIOL;
        end else if (unsigned_sw) begin
          rts_d = DSC_RTS_NONSEC;
        end else if (sw_nonsec_req) begin
          rts_d = DSC_RTS_NONSEC;
        end
      end
      DSC_RTS_NONSEC: begin
        if (sec_fault) begin
          rts_d = DSC_RTS_VIOL;
        end
      end
      DSC_RTS_VIOL: begin
        // only a reset leaves violation
        rts_d = DSC_RTS_VIOL;
      end
      default: begin
        rts_d = DSC_RTS_VIOL;
      end
    endcase
  end

  // mkey, secure storage and csr answers
  always_comb begin
    mkey_d  = mkey_q;
    store_d = store_q;
    rdata_d = 32'h0;
    ack_d   = 1'b0;
    deny_d  = 1'b0;
    if (rts_d != rts_s_q) begin
      case (rts_d)
        DSC_RTS_SECURE: mkey_d = chip_key;
        DSC_RTS_VIOL:   mkey_d = 256'h0;
        // leaving secure drops the key so later reads cannot see it
        DSC_RTS_NONSEC: mkey_d = MKEY_RST;
        default:        mkey_d = MKEY_RST;
      endcase
    end else if (csr_req) begin
      ack_d = 1'b1;
      if (!access_ok(csr_addr, csr_we, rts_s_q, lc_now)) begin
        deny_d = 1'b1;
      end else if (csr_addr[11:3] == CSR_MKEY_BASE[11:3]) begin
        if (csr_we) begin
          mkey_d[csr_addr[2:0]*32 +: 32] = csr_wdata;
        end else begin
          rdata_d = mkey_q[csr_addr[2:0]*32 +: 32];
        end
      end else if (csr_addr == CSR_DEV_STATE) begin
        rdata_d[DEV_STATE_RTS_LSB +: 2] = rts_s_q;
        rdata_d[DEV_STATE_LC_LSB +: 2]  = lc_now;
      end else begin
        if (csr_we) begin
          store_d = csr_wdata;
        end else begin
          rdata_d = store_q;
        end
      end
    end
  end

  // life-cycle advance, one step at a time
  always_comb begin
    burn_req = 1'b0;
    burn_val = lc_bus.fuse_val;
    lc_d     = lc_now;
    // the step needs secure, or the blank factory state before any secrets exist
    if (lc_adv_req && ((rts_s_q == DSC_RTS_SECURE) ||
        ((lc_now == DSC_LC_UNLK_FACT) && (rts_s_q != DSC_RTS_VIOL)))) begin
      burn_req = 1'b1;
      case (lc_now)
        DSC_LC_UNLK_FACT: burn_val = LC_FUSE_LOCK_FACT;
        DSC_LC_LOCK_FACT: burn_val = LC_FUSE_UNLOCKED;
        DSC_LC_UNLOCKED:  burn_val = LC_FUSE_LOCKED;
        default:          burn_val = LC_FUSE_LOCKED;
      endcase
    end
  end

  assign lc_bus.burn_req = burn_req;
  assign lc_bus.burn_val = burn_val;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rts_s_q          <= DSC_RTS_EVAL;
      mkey_q           <= MKEY_RST;
      store_q          <= SEC_STORE_RST;
      csr_rdata_q      <= 32'h0;
      csr_ack_q        <= 1'b0;
      csr_deny_q       <= 1'b0;
      rts_q            <= DSC_RTS_EVAL;
      lc_state_q       <= DSC_LC_LOCKED;
      crypto_key_q     <= 256'h0;
      crypto_key_vld_q <= 1'b0;
    end else begin
      rts_s_q          <= rts_d;
      mkey_q           <= mkey_d;
      store_q          <= store_d;
      csr_rdata_q      <= rdata_d;
      csr_ack_q        <= ack_d;
      csr_deny_q       <= deny_d;
      rts_q            <= rts_d;
      lc_state_q       <= lc_d;
      // crypto engines see the key only while secure
      crypto_key_q     <= (rts_d == DSC_RTS_SECURE) ? mkey_d : 256'h0;
      crypto_key_vld_q <= (rts_d == DSC_RTS_SECURE);
    end
  end

endmodule : dsc_state_ctrl
`default_nettype wire

// *** dv/dsc_state_ctrl_props.sv ***
// assertions on the state controller ports.
// assumes it is bound to dsc_state_ctrl.
`timescale 1ns/1ps
`default_nettype none
module dsc_state_ctrl_props
  import dsc_pkg::*;
(
  // clock, reset, causes
  input wire logic         ref_clk,
  input wire logic         rst_b,
  input wire logic         boot_done,
  input wire logic         boot_ok,
  input wire logic         boot_err,
  input wire logic         sec_fault,
  input wire logic         unsigned_sw,
  input wire logic         csr_req,
  input wire logic [255:0] chip_key,
  // results
  input wire logic         csr_ack_q,
  input wire logic         csr_deny_q,
  input wire logic [31:0]  csr_rdata_q,
  input wire logic [1:0]   rts_q,
  input wire logic [1:0]   lc_state_q,
  input wire logic [255:0] crypto_key_q,
  input wire logic         crypto_key_vld_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_rst_to_eval: assert property (disable iff (1'b0) !rst_b |=> rts_q == 2'h0)
    else $error("run-time state not evaluate after reset");
  a_boot_to_sec: assert property (rts_q == 2'h0 && boot_done && boot_ok && !boot_err
    && !sec_fault && !unsigned_sw |=> rts_q == 2'h1 && crypto_key_q == $past(chip_key))
    else $error("good boot did not give secure with key");
  a_err_to_viol: assert property (rts_q == 2'h0 && (boot_err || sec_fault) |=> rts_q == 2'h3)
    else $error("boot error did not give violation");
  a_viol_sticks: assert property (rts_q == 2'h3 |=> $stable(rts_q))
    else $error("violation left without reset");
  a_key_gated: assert property (rts_q != 2'h1 |-> crypto_key_q == 256'h0 && !crypto_key_vld_q)
    else $error("key visible outside secure");
  a_ack_cause: assert property (csr_ack_q |-> $past(csr_req))
    else $error("ack without request");
  a_deny_empty: assert property (csr_deny_q |-> csr_ack_q && csr_rdata_q == 32'h0)
    else $error("deny without ack or with data");
  a_lc_forward: assert property ($past(rst_b, 3) && $past(rst_b, 2) && $past(rst_b)
    |-> lc_state_q >= $past(lc_state_q))
    else $error("life-cycle went backwards");
  a_sec_key_vld: assert property (rts_q == 2'h1 |-> crypto_key_vld_q)
    else $error("key not valid while secure");
endmodule // dsc_state_ctrl_props
`default_nettype wire

// *** dv/dsc_cpu_model.sv ***
// cpu model: boot rom and machine-mode software strobes.
// assumes the bench sets cmd just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module dsc_cpu_model (
  // clock
  input  wire logic       ref_clk,
  // bench command, strobes to the controller
  input  wire logic [6:0] cmd,
  output logic      [6:0] ev
);
  // registered so strobes leave on an edge like real software writes
  always_ff @(posedge ref_clk) ev <= cmd;
endmodule // dsc_cpu_model
`default_nettype wire

// *** dv/tb.sv ***
// top bench: every step is judged through csr reads.
// assumes blank fuses at start and the cpu model as event source.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dsc_pkg::*;
  localparam logic [32:0] D = 33'h100000000;
  logic         ref_clk    = 1'h0;
  logic         rst_b      = 1'h0;
  logic         blank_b    = 1'h0;
  logic [6:0]   cmd        = '0;
  logic [6:0]   ev;
  logic [255:0] key        = '0;
  logic         req        = 1'h0;
  logic         we         = 1'h0;
  logic [11:0]  addr       = '0;
  logic [31:0]  wd         = '0;
  logic [31:0]  w;
  logic [31:0]  rd;
  logic         ack;
  logic         deny;
  logic [32:0]  e;
  logic [32:0]  exp_q[$];
  logic [31:0]  seed       = 32'he592ce58;
  int           error_cnt  = 0;
  int           n_compared = 0;

  dsc_cpu_model i_dsc_cpu_model (.ref_clk(ref_clk), .cmd(cmd), .ev(ev));
  dsc_state_ctrl i_dsc_state_ctrl (.ref_clk(ref_clk), .rst_b(rst_b), .fuse_blank_b(blank_b),
    .boot_done(ev[6]), .boot_ok(ev[5]), .boot_err(ev[4]), .unsigned_sw(ev[3]), .sw_nonsec_req(ev[2]),
    .sec_fault(ev[1]), .lc_adv_req(ev[0]), .chip_key(key), .csr_req(req), .csr_we(we), .csr_addr(addr),
    .csr_wdata(wd), .csr_rdata_q(rd), .csr_ack_q(ack), .csr_deny_q(deny), .rts_q(), .lc_state_q(),
    .crypto_key_q(), .crypto_key_vld_q());

  initial forever #10 ref_clk = ~ref_clk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic csr(input logic c_we, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x);
    exp_q.push_back(x);
    @(posedge ref_clk);
    #1;
    {req, we, addr, wd} = {1'b1, c_we, a, d};
    @(posedge ref_clk);
    #1;
    req = 1'h0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [32:0] x);
    csr(1'h0, a, 32'h0, x);
  endtask

  task automatic wrc(input logic [11:0] a, input logic [31:0] d, input logic [32:0] x);
    csr(1'h1, a, d, x);
  endtask

  // strobe order: done, ok, err, unsigned, nonsec req, fault, lc advance
  task automatic evt(input logic [6:0] v);
    @(posedge ref_clk);
    #1;
    cmd = v;
    @(posedge ref_clk);
    #1;
    cmd = '0;
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic rst();
    @(posedge ref_clk);
    #1;
    rst_b = 1'h0;
    repeat (2) @(posedge ref_clk);
    #1;
    rst_b = 1'h1;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic print_verdict();
    // a request that never got its answer leaves a note behind
    if (exp_q.size() != 0) begin
      error_cnt++;
      $display("unexpected csr_acks_missing exp=0 got=%0d", exp_q.size());
    end
    $display("errors %0d compares %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // answers stand one full cycle, so the falling edge sees them settled
  always @(negedge ref_clk) begin
    if (ack === 1'h1) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
      n_compared++;
      if ({deny, rd} !== e) begin
        error_cnt++;
        $display("unexpected csr_resp exp=%h got=%h", e, {deny, rd});
      end
    end
  end

  initial begin
    repeat (2000) @(posedge ref_clk);
    error_cnt++;
    print_verdict();
  end

  initial begin
    for (int i = 0; i < 8; i++) key[32*i +: 32] = xs();
    w = xs();
    repeat (6) @(posedge ref_clk);
    #1;
    rst_b = 1'h1;
    blank_b = 1'h1;
    repeat (3) @(posedge ref_clk);
    rdc(CSR_MKEY_BASE, D);
    rdc(CSR_DEV_STATE, 33'h0);
    rdc(CSR_SEC_STORE, {1'h0, SEC_STORE_RST});
    rdc(12'h7ff, D);
    wrc(CSR_DEV_STATE, 32'h5, D);
    evt(7'h60);
    rdc(CSR_DEV_STATE, 33'h1);
    for (int i = 0; i < 8; i++) rdc(CSR_MKEY_BASE + 12'(i), {1'h0, key[32*i +: 32]});
    wrc(CSR_MKEY_BASE + 12'h3, w, 33'h0);
    rdc(CSR_MKEY_BASE + 12'h3, {1'h0, w});
    wrc(CSR_SEC_STORE, w, 33'h0);
    rdc(CSR_SEC_STORE, {1'h0, w});
    evt(7'h04);
    rdc(CSR_DEV_STATE, 33'h2);
    rdc(CSR_MKEY_BASE, D);
    evt(7'h02);
    rdc(CSR_DEV_STATE, 33'h3);
    rst();
    rdc(CSR_DEV_STATE, 33'h0);
    evt(7'h08);
    rdc(CSR_DEV_STATE, 33'h2);
    rst();
    evt(7'h01);
    rdc(CSR_DEV_STATE, 33'h4);
    rst();
    rdc(CSR_DEV_STATE, 33'h4);
    rdc(CSR_SEC_STORE, D);
    evt(7'h04);
    rdc(CSR_DEV_STATE, 33'h4);
    evt(7'h08);
    rdc(CSR_DEV_STATE, 33'h7);
    evt(7'h01);
    rdc(CSR_DEV_STATE, 33'h7);
    rst();
    evt(7'h60);
    evt(7'h04);
    rdc(CSR_DEV_STATE, 33'h6);
    rst();
    evt(7'h10);
    rdc(CSR_DEV_STATE, 33'h7);
    rdc(CSR_MKEY_BASE, D);
    // fuses never go back, so the later life-cycle steps come last
    rst();
    evt(7'h60);
    evt(7'h01);
    rdc(CSR_DEV_STATE, 33'h9);
    evt(7'h08);
    rdc(CSR_DEV_STATE, 33'ha);
    rst();
    rdc(CSR_SEC_STORE, D);
    evt(7'h40);
    rdc(CSR_DEV_STATE, 33'hb);
    rst();
    evt(7'h60);
    evt(7'h02);
    rdc(CSR_DEV_STATE, 33'hb);
    rdc(CSR_MKEY_BASE + 12'h7, D);
    rst();
    evt(7'h60);
    evt(7'h01);
    rdc(CSR_DEV_STATE, 33'hd);
    evt(7'h01);
    rdc(CSR_DEV_STATE, 33'hd);
    evt(7'h08);
    rdc(CSR_DEV_STATE, 33'hf);
    repeat (3) @(posedge ref_clk);
    print_verdict();
  end
endmodule // tb

bind dsc_state_ctrl dsc_state_ctrl_props i_props (.ref_clk(ref_clk), .rst_b(rst_b), .boot_done(boot_done),
  .boot_ok(boot_ok), .boot_err(boot_err), .sec_fault(sec_fault), .unsigned_sw(unsigned_sw),
  .csr_req(csr_req), .chip_key(chip_key), .csr_ack_q(csr_ack_q), .csr_deny_q(csr_deny_q),
  .csr_rdata_q(csr_rdata_q), .rts_q(rts_q), .lc_state_q(lc_state_q), .crypto_key_q(crypto_key_q),
  .crypto_key_vld_q(crypto_key_vld_q));
`default_nettype wire
